// ==== design/lps_pkg.sv ====
package lps_pkg;
  // Word and buffer sizes
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W = 13;

  // Positions inside the synchronised pin vector
  localparam int POS_CAP_CLK = 12;
  localparam int POS_SHIFT_CLK = 11;
  localparam int POS_LOAD_N = 10;
  localparam int POS_CLEAR_N = 9;
  localparam int POS_SER = 8;
  localparam int POS_PAR_LSB = 0;

  // Values after reset
  localparam logic [12:0] SYNC_RESET = 13'h0600;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
endpackage : lps_pkg

// ==== design/lps_fifo.sv ====
`timescale 1ns/10ps
module lps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] lps_ptr_inc(input logic [AW-1:0] ptr);
    lps_ptr_inc = (ptr == AW'(DEPTH - 1)) ? '0 : ptr + AW'(1);
  endfunction : lps_ptr_inc

  assign push = i_in_valid && !full_reg;
  assign pop = !empty_reg && i_out_ready;
  assign o_in_ready = !full_reg;
  assign o_out_valid = !empty_reg;
  assign o_out_data = mem_reg[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= lps_ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= lps_ptr_inc(rd_ptr_reg);
      end
      count_reg <= count_next;
      full_reg <= (count_next == (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end
endmodule : lps_fifo

// ==== design/lps_shift_top.sv ====
// Functional notes
// - An eight-bit input latch feeds an eight-bit parallel-load shift register emptied serially.
// - Latch and shift register change only on their own clock edges, apart from load and clear.
// - Every rising edge of the latch-capture clock stores the eight parallel inputs, unless the capture buffer is full.
// - A capture edge while load is low and clear high passes the new word into the shift register.
// - While load is low and clear high the shift register follows the latch without a shift edge.
// - While clear is low and load high every stage is forced to zero, overriding shifting.
// - Load is a direct latch to shift register path independent of the shift clock.
// - A shift edge with load and clear high moves each stage up and takes the serial input bit.
// - The serial output always shows the last stage of the shift register.
`timescale 1ns/10ps
module lps_shift_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Controller pins
  input wire logic i_latch_capture_clock,
  input wire logic i_shift_clock,
  input wire logic i_parallel_load_n,
  input wire logic i_shift_clear_n,
  input wire logic i_serial_in_bit,
  input wire logic [lps_pkg::DATA_W-1:0] i_parallel_data,
  // Outputs
  output logic o_serial_out,
  output logic o_capture_ready
);
  localparam int W = lps_pkg::DATA_W;
  localparam int CNT_W = $clog2(W) + 1;

  logic [lps_pkg::SYNC_W-1:0] sync1_reg;
  logic [lps_pkg::SYNC_W-1:0] sync2_reg;
  logic cap_clk_dly_reg;
  logic shift_clk_dly_reg;
  logic [W-1:0] latch_reg;
  logic [W-1:0] shift_reg;
  logic [W-1:0] shift_next;
  logic cap_edge;
  logic shift_edge;
  logic load_lvl;
  logic clear_lvl;
  logic ser_bit;
  logic [W-1:0] par_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [W-1:0] fifo_out_data;
  logic drain_ready;
  logic load_on;
  logic clear_on;
  logic shift_on;
  logic [CNT_W-1:0] shift_cnt_reg;
  logic first_ser_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= lps_pkg::SYNC_RESET;
      sync2_reg <= lps_pkg::SYNC_RESET;
    end else begin
      sync1_reg <= {i_latch_capture_clock, i_shift_clock, i_parallel_load_n, i_shift_clear_n,
                    i_serial_in_bit, i_parallel_data};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_clk_dly_reg <= 1'b0;
      shift_clk_dly_reg <= 1'b0;
    end else begin
      cap_clk_dly_reg <= sync2_reg[lps_pkg::POS_CAP_CLK];
      shift_clk_dly_reg <= sync2_reg[lps_pkg::POS_SHIFT_CLK];
    end
  end

  function automatic logic lps_rise(input logic now_lvl, input logic was_lvl);
    lps_rise = now_lvl && !was_lvl;
  endfunction : lps_rise

  assign cap_edge = lps_rise(sync2_reg[lps_pkg::POS_CAP_CLK], cap_clk_dly_reg);
  assign shift_edge = lps_rise(sync2_reg[lps_pkg::POS_SHIFT_CLK], shift_clk_dly_reg);
  assign load_lvl = sync2_reg[lps_pkg::POS_LOAD_N];
  assign clear_lvl = sync2_reg[lps_pkg::POS_CLEAR_N];
  assign ser_bit = sync2_reg[lps_pkg::POS_SER];
  assign par_word = sync2_reg[lps_pkg::POS_PAR_LSB +: W];
  assign load_on = !load_lvl && clear_lvl;
  assign clear_on = load_lvl && !clear_lvl;
  assign shift_on = load_lvl && clear_lvl && shift_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Capture buffer and input latch

  lps_fifo #(
    .WIDTH(W),
    .DEPTH(lps_pkg::FIFO_DEPTH)
  ) u_capture_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_in_valid(cap_edge),
    .i_in_data(par_word),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(drain_ready)
  );

  // Words wait in the buffer while clear is held
  assign drain_ready = clear_lvl;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      latch_reg <= lps_pkg::LATCH_RESET;
    end else if (fifo_out_valid && drain_ready) begin
      latch_reg <= fifo_out_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_capture_ready <= 1'b1;
    end else begin
      o_capture_ready <= fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register

  always_comb begin
    shift_next = shift_reg;
    unique case ({load_lvl, clear_lvl})
      2'b00: shift_next = shift_reg;
      2'b10: shift_next = '0;
      2'b01: shift_next = latch_reg;
      2'b11: shift_next = shift_edge ? {shift_reg[W-2:0], ser_bit} : shift_reg;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_reg <= lps_pkg::SHIFT_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign o_serial_out = shift_reg[W-1];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Shifts since the last load or clear, saturating at the register length
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_cnt_reg <= '0;
      first_ser_reg <= 1'b0;
    end else if (load_on || clear_on) begin
      shift_cnt_reg <= '0;
    end else if (shift_on) begin
      if (shift_cnt_reg == '0) begin
        first_ser_reg <= ser_bit;
      end
      if (shift_cnt_reg != CNT_W'(W)) begin
        shift_cnt_reg <= shift_cnt_reg + CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  a_clear_zeroes_all: assert property (clear_on |=> shift_reg == '0)
    else $error("clear did not empty shift register");
  a_load_follows_latch: assert property (load_on |=> shift_reg == $past(latch_reg))
    else $error("shift register did not follow latch");
  a_shift_moves_stage: assert property (shift_on |=> shift_reg == {$past(shift_reg[W-2:0]), $past(ser_bit)})
    else $error("shift edge moved wrong data");
  a_idle_holds_data: assert property (load_lvl && clear_lvl && !shift_edge |=> $stable(shift_reg))
    else $error("shift register changed without cause");
  a_out_last_stage: assert property (shift_on |=> o_serial_out == $past(shift_reg[W-2]))
    else $error("serial output not last stage");
  a_capture_to_latch: assert property ((cap_edge && !fifo_out_valid && clear_lvl) ##1 clear_lvl
                                       |=> latch_reg == $past(par_word, 2))
    else $error("captured word not in latch");
  a_capture_through_load: assert property ((cap_edge && !fifo_out_valid && load_on) ##1 load_on ##1 load_on
                                           |=> shift_reg == $past(par_word, 3))
    else $error("captured word did not pass to shift register");
  a_latch_no_spurious: assert property (!fifo_out_valid |=> $stable(latch_reg))
    else $error("latch changed without capture");
  a_both_low_holds: assert property (!load_lvl && !clear_lvl |=> $stable(shift_reg))
    else $error("shift register changed with both lines low");
  a_clear_out_low: assert property (clear_on |=> !o_serial_out)
    else $error("serial output not low after clear");
  a_load_out_bit: assert property (load_on |=> o_serial_out == $past(latch_reg[W-1]))
    else $error("serial output not latch top bit during load");
  a_capture_enters_buffer: assert property (cap_edge && fifo_in_ready |=> fifo_out_valid)
    else $error("accepted capture not buffered");
  a_ready_reflects_full: assert property (!fifo_in_ready |=> !o_capture_ready)
    else $error("capture ready high with full buffer");
  a_clear_holds_latch: assert property (!clear_lvl |=> $stable(latch_reg))
    else $error("latch changed while clear held");
  a_first_bit_out: assert property (shift_on && shift_cnt_reg == CNT_W'(W - 1)
                                    |=> o_serial_out == first_ser_reg)
    else $error("first serial bit not at output after eight shifts");

  // Main scenarios
  c_shift_event: cover property (shift_on ##[1:40] shift_on);
  c_capture_load: cover property (cap_edge && load_on);
  c_buffer_full: cover property (!fifo_in_ready);
  c_clear_event: cover property (clear_on ##1 !clear_on);
  c_load_event: cover property (load_on ##1 !load_on);
endmodule : lps_shift_top

// ==== verification/lps_ctrl_model.sv ====
`timescale 1ns/10ps
module lps_ctrl_model (
  // Clock
  input wire logic i_clock,
  // Pins towards the block
  output logic o_latch_capture_clock,
  output logic o_shift_clock,
  output logic o_parallel_load_n,
  output logic o_shift_clear_n,
  output logic o_serial_in_bit,
  output logic [7:0] o_parallel_data
);
  initial begin
    o_latch_capture_clock = 1'b0;
    o_shift_clock = 1'b0;
    o_parallel_load_n = 1'b1;
    o_shift_clear_n = 1'b1;
    o_serial_in_bit = 1'b0;
    o_parallel_data = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
  endtask : hold

  task automatic pins(input logic ld_n, input logic clr_n);
    @(posedge i_clock);
    o_parallel_load_n <= ld_n | ~clr_n;
    o_shift_clear_n <= clr_n;
  endtask : pins

  // Data set 3 cycles before the rising edge; serial bit held 4 cycles after it
  task automatic pulse(input bit cap, input logic serial_in_bit, input logic [7:0] d);
    @(posedge i_clock);
    o_parallel_data <= d;
    o_serial_in_bit <= serial_in_bit;
    hold(3);
    if (cap) o_latch_capture_clock <= 1'b1;
    else o_shift_clock <= 1'b1;
    hold(4);
    o_latch_capture_clock <= 1'b0;
    o_shift_clock <= 1'b0;
    o_serial_in_bit <= ~serial_in_bit;
    hold(4);
  endtask : pulse
endmodule : lps_ctrl_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic i_clock, i_rst_b, cap, sck, ld_n, clr_n, serial_in_bit, so, rdy, got;
  logic [7:0] par, word, last, sbits;
  logic [1:0] note;
  logic [1:0] exp_q[$];
  int failures, num_checks, cycles, k;
  int seed = 32'h27bdef6a;
  event sample;

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  lps_ctrl_model u_lps_ctrl_model (.i_clock(i_clock), .o_latch_capture_clock(cap), .o_shift_clock(sck),
    .o_parallel_load_n(ld_n), .o_shift_clear_n(clr_n), .o_serial_in_bit(serial_in_bit), .o_parallel_data(par));
  lps_shift_top u_lps_shift_top (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_latch_capture_clock(cap),
    .i_shift_clock(sck), .i_parallel_load_n(ld_n), .i_shift_clear_n(clr_n), .i_serial_in_bit(serial_in_bit),
    .i_parallel_data(par), .o_serial_out(so), .o_capture_ready(rdy));

  // Note: sel 1 = capture ready, 0 = serial out
  task automatic expect_out(input logic sel, input logic v);
    u_lps_ctrl_model.hold(6);
    #1;
    exp_q.push_back({sel, v});
    -> sample;
  endtask : expect_out

  always @(sample) begin
    note = exp_q.pop_front();
    got = note[1] ? rdy : so;
    num_checks++;
    if (got !== note[0]) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, note[0]);
    end
  end

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    i_rst_b = 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    word = $random(seed);
    sbits = $random(seed);
    u_lps_ctrl_model.pulse(1, 0, word);
    u_lps_ctrl_model.pins(0, 1);
    expect_out(0, word[7]);
    u_lps_ctrl_model.pins(1, 1);
    for (k = 1; k <= 15; k++) begin
      u_lps_ctrl_model.pulse(0, sbits[(k - 1) % 8], word);
      expect_out(0, (k < 8) ? word[7 - k] : sbits[k - 8]);
    end
    $display("test load and shift done");
    u_lps_ctrl_model.pins(1, 0);
    expect_out(0, 1'b0);
    u_lps_ctrl_model.pulse(0, 1, word);
    expect_out(0, 1'b0);
    u_lps_ctrl_model.pins(0, 0);
    expect_out(0, 1'b0);
    $display("test clear done");
    u_lps_ctrl_model.pins(0, 1);
    for (k = 0; k < 4; k++) begin
      word = $random(seed);
      u_lps_ctrl_model.pulse(1, 0, word);
      expect_out(0, word[7]);
    end
    $display("test capture through done");
    u_lps_ctrl_model.pins(1, 0);
    for (k = 0; k <= 16; k++) begin
      word = $random(seed);
      if (k == 16) word[7] = ~last[7];
      u_lps_ctrl_model.pulse(1, 0, word);
      if (k == 15) last = word;
    end
    expect_out(1, 1'b0);
    u_lps_ctrl_model.pins(1, 1);
    u_lps_ctrl_model.hold(20);
    expect_out(1, 1'b1);
    u_lps_ctrl_model.pins(0, 1);
    expect_out(0, last[7]);
    $display("test buffer fill done");
    word = $random(seed);
    word[7] = 1'b1;
    u_lps_ctrl_model.pulse(1, 0, word);
    expect_out(0, 1'b1);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    expect_out(0, 1'b0);
    expect_out(1, 1'b1);
    @(posedge i_clock);
    i_rst_b <= 1'b1;
    expect_out(0, 1'b0);
    u_lps_ctrl_model.pulse(1, 0, word);
    expect_out(0, 1'b1);
    $display("test mid reset done");
    u_lps_ctrl_model.hold(2);
    close_out();
  end
endmodule : testbench
